/* hdl/flash_host_defines.vh */
/*
 * constants for the parallel flash host controller: command codes,
 * status bit positions and pin timing in nanoseconds with cycle counts.
 * assumes a 100 MHz system clock; included by bare name.
 */
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// ****************************************
// clock
// ****************************************
`define CLK_PERIOD_NS     10

// ****************************************
// pin timing, ns as printed, cycles rounded up
// ****************************************
`define T_WP_NS           50
`define T_WPH_NS          35
`define T_AH_NS           90
`define T_ACC_NS          85
`define T_RW_NS           50
`define T_OEHP_NS         50
`define T_RP_NS           500
`define T_RH_NS           50
`define CYC(ns)           (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// the same timings as counts for the 6-bit pin timer, rounded up to whole cycles, access time one cycle more
`define WP_CYC            6'h05
`define AH_CYC            6'h09
`define ACC_CYC           6'h0a
`define RW_CYC            6'h05
`define OEHP_CYC          6'h05
`define RP_CYC            6'h32
`define RH_CYC            6'h05

// ****************************************
// command codes and addresses
// ****************************************
`define CMD_UNLOCK1_ADDR  12'h555
`define CMD_UNLOCK2_ADDR  12'haaa
`define CMD_UNLOCK1_DATA  8'haa
`define CMD_UNLOCK2_DATA  8'h55
`define CMD_ERASE_SETUP   8'h80
`define CMD_CHIP_ERASE    8'h10
`define CMD_SECTOR_ERASE  8'h30
`define CMD_PROGRAM       8'ha0
`define CMD_ID_ENTRY      8'h90
`define CMD_ID_EXIT       8'hf0
`define CMD_SUSPEND       8'hb0
`define CMD_RESUME        8'h30

// ****************************************
// operation codes on the user side
// ****************************************
`define OP_READ           3'h0
`define OP_PROGRAM        3'h1
`define OP_CHIP_ERASE     3'h2
`define OP_SECTOR_ERASE   3'h3
`define OP_ID_ENTRY       3'h4
`define OP_ID_EXIT        3'h5
`define OP_SUSPEND        3'h6
`define OP_RESUME         3'h7

// ****************************************
// status bit positions
// ****************************************
`define DATA_POLL_POS     7
`define TOGGLE_POS        6
`define PLANE_TOGGLE_POS  2
`define ID_SELECT_POS     0

`endif

/* hdl/flash_cycle_timer.v */
/*
 * down counter that paces the pin phases of the flash host.
 * assumes a load pulse with a count; done is high once the count has run out.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_cycle_timer
(
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // control
   input  wire        load,
   input  wire [5:0]  count,
   // status
   output wire        done
);

   reg [5:0] remain;

   // a load of n makes done rise n+1 cycles after the cycle with load high
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         remain <= 6'h00;
      else if (load)
         remain <= count;
      else if (remain != 6'h00)
         remain <= remain - 6'h01;
   end

   assign done = (remain == 6'h00) && !load;

endmodule
`default_nettype wire

/* hdl/flash_host.v */
/*
 * host controller for an asynchronous parallel flash: issues command
 * sequences, reads, identification reads and toggle-status polling on the pins.
 * assumes one 100 MHz clock, the flash on its pins, and a user that waits for ready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.vh"

module flash_host
(
   // clock and reset
   input  wire         sys_clk,
   input  wire         arst_n,
   // user request
   input  wire         req_valid,
   output wire         req_ready,
   input  wire [2:0]   req_op,
   input  wire [20:0]  req_addr,
   input  wire [15:0]  req_data,
   // user answer
   output reg          rsp_valid,
   output reg  [15:0]  rsp_data,
   output reg          id_mode,
   // flash pins
   output reg  [20:0]  flash_addr,
   input  wire [15:0]  flash_dq_in,
   output reg  [15:0]  flash_dq_out,
   output reg          flash_dq_oe,
   output reg          flash_ce_n,
   output reg          flash_oe_n,
   output reg          flash_we_n,
   output reg          flash_reset_n
);

   // ****************************************
   // states and timing
   // ****************************************
   localparam [3:0] S_RST   = 4'h0;
   localparam [3:0] S_RREC  = 4'h1;
   localparam [3:0] S_IDLE  = 4'h2;
   localparam [3:0] S_WLOW  = 4'h3;
   localparam [3:0] S_WHIGH = 4'h4;
   localparam [3:0] S_RLOW  = 4'h5;
   localparam [3:0] S_RGAP  = 4'h6;
   localparam [3:0] S_PLOW  = 4'h7;
   localparam [3:0] S_PGAP  = 4'h8;

   localparam [5:0] C_WP   = `WP_CYC;
   localparam [5:0] C_WPH  = `AH_CYC;    // covers write high and address hold
   localparam [5:0] C_ACC  = `ACC_CYC;   // access time plus one spare cycle
   localparam [5:0] C_RW   = `RW_CYC;
   localparam [5:0] C_OEHP = `OEHP_CYC;
   localparam [5:0] C_RP   = `RP_CYC;
   localparam [5:0] C_RH   = `RH_CYC;

   // ****************************************
   // reset release and pin sampling
   // ****************************************
   reg        rst_s1;
   reg        rst_n;
   reg [15:0] dq_s1;
   reg [15:0] dq_s2;

   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // data pins come from outside the clock, so two flops before any use
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
      end
      else
      begin
         dq_s1 <= flash_dq_in;
         dq_s2 <= dq_s1;
      end
   end

   // ****************************************
   // command sequence lookup
   // ****************************************
   // returns {last, addr12, data8} for step n of an operation
   function [20:0] seq_step;
      input [2:0]  op;
      input [2:0]  n;
      input [11:0] a;
      input [7:0]  d;
      reg   [7:0]  cmd;
      begin
         cmd = `CMD_ID_EXIT;
         case (op)
            `OP_PROGRAM:      cmd = `CMD_PROGRAM;
            `OP_CHIP_ERASE:   cmd = `CMD_ERASE_SETUP;
            `OP_SECTOR_ERASE: cmd = `CMD_ERASE_SETUP;
            `OP_ID_ENTRY:     cmd = `CMD_ID_ENTRY;
            default:          cmd = `CMD_ID_EXIT;
         endcase
         seq_step = {1'b0, `CMD_UNLOCK1_ADDR, `CMD_UNLOCK1_DATA};
         if (op == `OP_SUSPEND)
            seq_step = {1'b1, a, `CMD_SUSPEND};
         else if (op == `OP_RESUME)
            seq_step = {1'b1, a, `CMD_RESUME};
         else if (n == 3'h1 || n == 3'h4)
            seq_step = {1'b0, `CMD_UNLOCK2_ADDR, `CMD_UNLOCK2_DATA};
         else if (n == 3'h2)
            seq_step = {(op != `OP_CHIP_ERASE && op != `OP_SECTOR_ERASE && op != `OP_PROGRAM),
                        `CMD_UNLOCK1_ADDR, cmd};
         else if (n == 3'h3 && op == `OP_PROGRAM)
            seq_step = {1'b1, a, d};
         // chip at 555, sector at address
         else if (n == 3'h5 && op == `OP_CHIP_ERASE)
            seq_step = {1'b1, `CMD_UNLOCK1_ADDR, `CMD_CHIP_ERASE};
         else if (n == 3'h5)
            seq_step = {1'b1, a, `CMD_SECTOR_ERASE};
      end
   endfunction

   // ****************************************
   // sequencer
   // ****************************************
   reg  [3:0] state;
   reg  [2:0] op;
   reg  [2:0] step;
   reg  [7:0] rec_data;
   reg        last_tog;
   reg        tload;
   reg  [5:0] tcount;
   wire       tdone;
   // request address kept apart, since the pins carry unlock addresses meanwhile
   reg  [20:0] op_addr;
   wire [20:0] cur = seq_step(op, step, op_addr[11:0], rec_data);

   flash_cycle_timer u_timer
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (tload),
      .count   (tcount),
      .done    (tdone)
   );

   assign req_ready = (state == S_IDLE) && tdone;

   // one process owns all pins so their phases never overlap
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state         <= S_RST;
         op            <= `OP_READ;
         step          <= 3'h0;
         rec_data      <= 8'h00;
         op_addr       <= 21'h000000;
         last_tog      <= 1'b0;
         tload         <= 1'b1;
         tcount        <= C_RP;
         rsp_valid     <= 1'b0;
         rsp_data      <= 16'h0000;
         id_mode       <= 1'b0;
         flash_addr    <= 21'h000000;
         flash_dq_out  <= 16'h0000;
         flash_dq_oe   <= 1'b0;
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_reset_n <= 1'b0;
      end
      else
      begin
         tload     <= 1'b0;
         rsp_valid <= 1'b0;
         case (state)
            S_RST:
               if (tdone && !tload)
               begin
                  flash_reset_n <= 1'b1;
                  tload         <= 1'b1;
                  tcount        <= C_RH;
                  state         <= S_RREC;
               end
            S_RREC:
               if (tdone && !tload)
               begin
                  id_mode <= 1'b0;
                  state   <= S_IDLE;
               end
            S_IDLE:
               if (req_valid && tdone)
               begin
                  op         <= req_op;
                  step       <= 3'h0;
                  rec_data   <= req_data[7:0];
                  op_addr    <= req_addr;
                  flash_addr <= req_addr;
                  flash_ce_n <= 1'b0;
                  if (req_op == `OP_READ)
                  begin
                     flash_oe_n <= 1'b0;
                     tload      <= 1'b1;
                     tcount     <= C_ACC;
                     state      <= S_RLOW;
                  end
                  else
                  begin
                     flash_we_n <= 1'b1;
                     state      <= S_WHIGH;
                     tload      <= 1'b1;
                     tcount     <= 6'h01;
                  end
               end
            // output enable stays high in writes
            // only low byte and 12 address bits
            S_WHIGH:
               if (tdone && !tload)
               begin
                  flash_addr   <= {flash_addr[20:12], cur[19:8]};
                  flash_dq_out <= {8'h00, cur[7:0]};
                  flash_dq_oe  <= 1'b1;
                  flash_oe_n   <= 1'b1;
                  flash_we_n   <= 1'b0;
                  tload        <= 1'b1;
                  tcount       <= C_WP;
                  state        <= S_WLOW;
               end
            S_WLOW:
               if (tdone && !tload)
               begin
                  flash_we_n <= 1'b1;
                  tload      <= 1'b1;
                  tcount     <= C_WPH;
                  if (cur[20])
                  begin
                     if (op == `OP_ID_ENTRY)
                        id_mode <= 1'b1;
                     else if (op == `OP_ID_EXIT)
                        id_mode <= 1'b0;
                     if (op == `OP_PROGRAM || op == `OP_CHIP_ERASE || op == `OP_SECTOR_ERASE ||
                         op == `OP_SUSPEND)
                        state <= S_PGAP;
                     else
                        state <= S_RGAP;
                  end
                  else
                  begin
                     step  <= step + 3'h1;
                     state <= S_WHIGH;
                  end
               end
            S_RLOW:
               if (tdone && !tload)
               begin
                  rsp_data   <= dq_s2;
                  rsp_valid  <= 1'b1;
                  flash_oe_n <= 1'b1;
                  tload      <= 1'b1;
                  tcount     <= C_RW;
                  state      <= S_RGAP;
               end
            S_RGAP:
               if (tdone && !tload)
               begin
                  flash_dq_oe <= 1'b0;
                  flash_ce_n  <= 1'b1;
                  if (op != `OP_READ)
                     rsp_valid <= 1'b1;
                  tload  <= 1'b1;
                  tcount <= C_RW;
                  state  <= S_IDLE;
               end
            // address held for the whole poll
            S_PGAP:
               if (tdone && !tload)
               begin
                  flash_dq_oe <= 1'b0;
                  flash_oe_n  <= 1'b0;
                  tload       <= 1'b1;
                  tcount      <= C_ACC;
                  state       <= S_PLOW;
               end
            S_PLOW:
               if (tdone && !tload)
               begin
                  flash_oe_n <= 1'b1;
                  last_tog   <= dq_s2[`TOGGLE_POS];
                  rsp_data   <= dq_s2;
                  tload      <= 1'b1;
                  tcount     <= C_OEHP;
                  if (step == 3'h7 && last_tog == dq_s2[`TOGGLE_POS])
                     state <= S_RGAP;
                  else
                  begin
                     step  <= 3'h7;
                     state <= S_PGAP;
                  end
               end
            default:
               state <= S_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

/* bench/flash_host_sva.sv */
/*
 * pin-level checker for the flash host.
 * assumes it is bound to flash_host and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_host_sva
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        arst_n,
   // user side
   input wire logic        req_ready,
   // flash pins
   input wire logic [20:0] flash_addr,
   input wire logic        flash_dq_oe,
   input wire logic        flash_ce_n,
   input wire logic        flash_oe_n,
   input wire logic        flash_we_n,
   input wire logic        flash_reset_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic [7:0] rst_low;
   // saturating count of cycles with the flash held in reset, so it never wraps
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         rst_low <= 8'h00;
      else
         rst_low <= flash_reset_n ? 8'h00 : rst_low + {7'h00, rst_low != 8'hff};
   end
   sequence s_we_low;
      !flash_we_n [*5];
   endsequence
   sequence s_quiet_after_read;
      (flash_oe_n && flash_we_n) [*5];
   endsequence
   sequence s_recover;
      (flash_oe_n && !req_ready) [*5];
   endsequence
   a_oe_off_write: assert property (!flash_we_n && !flash_ce_n |-> flash_oe_n)
      else $error("output enable low during a write");
   a_no_bus_fight: assert property (!flash_oe_n |-> !flash_dq_oe)
      else $error("host drives data during a read");
   a_write_pulse_len: assert property ($fell(flash_we_n) |-> s_we_low)
      else $error("write pulse too short");
   a_write_data_on: assert property (!flash_we_n |-> flash_dq_oe)
      else $error("write without data driven");
   a_write_addr_held: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr))
      else $error("address moved inside a write pulse");
   a_read_write_gap: assert property ($rose(flash_oe_n) |-> s_quiet_after_read)
      else $error("write or read too soon after a read");
   a_poll_addr_held: assert property (!flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr))
      else $error("address moved inside a read");
   a_reset_pulse_len: assert property ($rose(flash_reset_n) |-> rst_low >= 8'd50)
      else $error("flash reset pulse too short");
   a_reset_recovery: assert property ($rose(flash_reset_n) |-> s_recover)
      else $error("read too soon after flash reset");
endmodule
bind flash_host flash_host_sva chk_u (.sys_clk(sys_clk), .arst_n(arst_n), .req_ready(req_ready),
   .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n));
`default_nettype wire

/* bench/flash_model.sv */
/*
 * behavioural model of the parallel flash: command decode, status reads, id mode.
 * assumes the pins of one host; a sector erase clears the whole small array.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_model
#(
   parameter logic [15:0] MAKER_CODE  = 16'h00a1, // arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h00b2, // arbitrary value
   parameter int          BUSY_READS  = 6
)
(
   // pins
   input  wire logic [20:0] addr,
   input  wire logic [15:0] din,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        reset_n,
   output logic [15:0]      dq,
   // observation
   output logic             busy,
   output logic [7:0]       last_byte,
   output logic [20:0]      last_addr
);
   logic [15:0] mem [16];
   logic [15:0] drv = 16'h0000;
   logic        idm = 1'b0;
   logic        tog = 1'b1;
   logic        erasing;
   logic        pbit;
   logic        susp = 1'b0;
   logic [20:0] sus_addr = 21'h000000;
   int          step;
   int          left;
   initial
      foreach (mem[i]) mem[i] = 16'hffff;
   // released bus shows the inverse of the last word, not a kind stale value
   assign dq = (!ce_n && !oe_n) ? drv : ~drv;
   // writes are latched on the rising write strobe
   always @(posedge we_n or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // id mode never survives a reset or power cycle
         step = 0;
         idm = 1'b0;
         busy = 1'b0;
         susp = 1'b0;
      end
      else if (!ce_n)
      begin
         last_byte = din[7:0];
         last_addr = addr;
         // the word after the program code is stored, whatever its value
         if (step == 3)
         begin
            mem[addr[3:0]] = din;
            pbit = din[7];
            erasing = 1'b0;
            busy = 1'b1;
            left = BUSY_READS;
            step = 0;
         end
         // erase kind from the final byte; chip erase only at 555, runs longer
         else if (step == 5)
         begin
            if ((din[7:0] == 8'h10 && addr[11:0] == 12'h555) || din[7:0] == 8'h30)
            begin
               foreach (mem[i]) mem[i] = 16'hffff;
               erasing = 1'b1;
               busy = 1'b1;
               left = (din[7:0] == 8'h10) ? 2 * BUSY_READS : BUSY_READS;
            end
            step = 0;
         end
         else
         begin
            // only low address and low byte are decoded
            case (step)
               0: step = ({addr[11:0], din[7:0]} == 20'h555aa) ? 1 : 0;
               1: step = ({addr[11:0], din[7:0]} == 20'haaa55) ? 2 : 0;
               6: step = ({addr[11:0], din[7:0]} == 20'h555aa) ? 7 : 0;
               7: step = ({addr[11:0], din[7:0]} == 20'haaa55) ? 5 : 0;
               2: step = (din[7:0] == 8'ha0) ? 3 : (din[7:0] == 8'h80) ? 6 : 0;
               default: step = 0;
            endcase
            if (din[7:0] == 8'h90 && addr[11:0] == 12'h555 && step == 0)
               idm = 1'b1;
            if (din[7:0] == 8'hf0)
               idm = 1'b0;
            // suspend parks a running erase, resume restarts it
            if (din[7:0] == 8'hb0 && busy && erasing)
            begin
               susp = 1'b1;
               sus_addr = addr;
               busy = 1'b0;
            end
            else if (din[7:0] == 8'h30 && susp && !busy)
            begin
               susp = 1'b0;
               erasing = 1'b1;
               busy = 1'b1;
               left = BUSY_READS;
            end
         end
      end
   end
   // each read strobe picks the word to present
   always @(negedge oe_n)
   begin
      if (!ce_n && reset_n)
      begin
         if (busy)
         begin
            // toggle flips per read, poll bit inverted or zero
            tog = ~tog;
            drv = {8'h00, erasing ? 1'b0 : ~pbit, tog, 3'b000, (erasing || susp) ? tog : 1'b1, 2'b00};
            left = left - 1;
            busy = (left > 0);
         end
         // the suspended sector reads ones on poll and toggle, bit 2 alternating
         else if (susp && addr[20:15] == sus_addr[20:15])
         begin
            tog = ~tog;
            drv = {8'h00, 1'b1, 1'b1, 3'b000, tog, 2'b00};
         end
         // id select line picks maker or device code
         else if (idm && addr[20:1] == 20'h00000)
            drv = addr[0] ? DEVICE_CODE : MAKER_CODE;
         else
            drv = mem[addr[3:0]];
      end
   end
endmodule
`default_nettype wire

/* bench/flash_host_test.sv */
/*
 * self-checking bench for the flash host with the flash model on its pins.
 * assumes the defines header on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.vh"
module flash_host_test;
   localparam logic [15:0] MAKER  = 16'h00a1; // arbitrary value
   localparam logic [15:0] DEVICE = 16'h00b2; // arbitrary value
   typedef struct {logic [2:0] op; logic [20:0] a; logic [15:0] d; logic [20:0] ea; logic [15:0] ev; logic id;} row_t;
   logic sys_clk = 1'b0, arst_n, req_valid, req_ready, rsp_valid, id_mode, dq_oe, ce_n, oe_n, we_n, rst_n;
   logic [2:0]  req_op;
   logic [20:0] req_addr, f_addr, last_addr;
   logic [15:0] req_data, rsp_data, dq_out, dq_dev, r;
   logic [7:0]  last_byte;
   logic        busy;
   int          error_cnt = 0, n_tests = 0, cyc = 0;
   row_t rows [14] = '{
      '{`OP_PROGRAM, 21'h12005, 16'h0034, 21'h12005, 16'h0034, 1'b0},
      '{`OP_READ, 21'h12005, 16'h0000, 21'h0, 16'h0034, 1'b0},
      '{`OP_CHIP_ERASE, 21'h0, 16'h0, 21'h00555, 16'h0010, 1'b0},
      '{`OP_READ, 21'h12005, 16'h0000, 21'h0, 16'hffff, 1'b0},
      '{`OP_PROGRAM, 21'h00009, 16'h00a5, 21'h00009, 16'h00a5, 1'b0},
      '{`OP_SECTOR_ERASE, 21'h08009, 16'h0, 21'h08009, 16'h0030, 1'b0},
      '{`OP_READ, 21'h00009, 16'h0000, 21'h0, 16'hffff, 1'b0},
      '{`OP_ID_ENTRY, 21'h0, 16'h0, 21'h00555, 16'h0090, 1'b1},
      '{`OP_READ, 21'h0, 16'h0, 21'h0, MAKER, 1'b1},
      '{`OP_READ, 21'h1, 16'h0, 21'h0, DEVICE, 1'b1},
      '{`OP_ID_EXIT, 21'h0, 16'h0, 21'h00555, 16'h00f0, 1'b0},
      '{`OP_READ, 21'h1, 16'h0, 21'h0, 16'hffff, 1'b0},
      '{`OP_SUSPEND, 21'h08009, 16'h0, 21'h08009, 16'h00b0, 1'b0},
      '{`OP_RESUME, 21'h08009, 16'h0, 21'h08009, 16'h0030, 1'b0}};
   // clock, 10 ns period
   always #5 sys_clk = ~sys_clk;
   flash_host dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .id_mode(id_mode), .flash_addr(f_addr),
      .flash_dq_in(dq_oe ? dq_out : dq_dev), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n));
   flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .BUSY_READS(6)) dev_u (.addr(f_addr),
      .din(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n), .dq(dq_dev),
      .busy(busy), .last_byte(last_byte), .last_addr(last_addr));
   task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // request held until taken, then wait for the answer pulse
   task automatic do_op(input logic [2:0] op, input logic [20:0] a, input logic [15:0] d);
      int k;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      k = 0;
      do begin @(negedge sys_clk); k++; end while (req_ready !== 1'b1 && k < 3000);
      chk("ready seen", 21'(1), 21'(req_ready));
      @(posedge sys_clk);
      req_valid <= 1'b0;
      k = 0;
      do begin @(negedge sys_clk); k++; end while (rsp_valid !== 1'b1 && k < 3000);
      chk("answer seen", 21'(1), 21'(rsp_valid));
      r = rsp_data;
   endtask
   // bounds a hang; the whole run needs far fewer cycles
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   initial
   begin
      arst_n = 1'b0;
      req_valid = 1'b0;
      req_op = 3'h0;
      req_addr = 21'h0;
      req_data = 16'h0;
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      foreach (rows[i])
      begin
         do_op(rows[i].op, rows[i].a, rows[i].d);
         if (rows[i].op == `OP_READ)
            chk("read word", 21'(rows[i].ev), 21'(r));
         else
         begin
            chk("final byte", 21'(rows[i].ev), 21'(last_byte));
            chk("final addr", rows[i].ea, last_addr);
            chk("flash busy", 21'(0), 21'(busy));
         end
         chk("id mode", 21'(rows[i].id), 21'(id_mode));
      end
      // id mode dropped by a reset in mid-run
      do_op(`OP_ID_ENTRY, 21'h0, 16'h0);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(negedge sys_clk);
      chk("id after reset", 21'(0), 21'(id_mode));
      do_op(`OP_READ, 21'h0, 16'h0);
      chk("read after reset", 21'(16'hffff), 21'(r));
      finish_test();
   end
endmodule
`default_nettype wire
